// File: core/pmsc_pkg.sv
/*
 * Shared constants of the power monitor and stop-mode control block:
 * APB register offsets, bit positions inside the two 8-bit control
 * registers and the event registers, and reset values.
 * Assumes a 32-bit APB with 12-bit byte addresses.
 */
package pmsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int PMSC_ADDR_W = 12;
    localparam int PMSC_DATA_W = 32;
    localparam int PMSC_REG_W  = 8;
    localparam int PMSC_EVT_W  = 3;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [11:0] PMSC_ADDR_CTRL1    = 12'h000;
    localparam logic [11:0] PMSC_ADDR_CTRL2    = 12'h004;
    localparam logic [11:0] PMSC_ADDR_EVT_STS  = 12'h008;
    localparam logic [11:0] PMSC_ADDR_EVT_MASK = 12'h00C;

    ////////////////////////////////////////////////////////////////////////
    // Control register 1 bit positions
    localparam int C1_DETECT_FLAG = 7;
    localparam int C1_DETECT_ACK  = 6;
    localparam int C1_IRQ_EN      = 5;
    localparam int C1_RST_EN      = 4;
    localparam int C1_STOP_EN     = 3;
    localparam int C1_LOGIC_EN    = 2;

    ////////////////////////////////////////////////////////////////////////
    // Control register 2 bit positions
    localparam int C2_WARN_FLAG = 7;
    localparam int C2_WARN_ACK  = 6;
    localparam int C2_DET_TRIP  = 5;
    localparam int C2_WARN_TRIP = 4;
    localparam int C2_PPD_FLAG  = 3;
    localparam int C2_PPD_ACK   = 2;
    localparam int C2_PD_ALLOW  = 1;
    localparam int C2_PD_KIND   = 0;

    ////////////////////////////////////////////////////////////////////////
    // Event status and mask bit positions
    localparam int EVT_DETECT = 0;
    localparam int EVT_WARN   = 1;
    localparam int EVT_PPD    = 2;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic RST_IRQ_EN   = 1'h0;
    localparam logic RST_RST_EN   = 1'h1;
    localparam logic RST_STOP_EN  = 1'h0;
    localparam logic RST_LOGIC_EN = 1'h1;
    localparam logic RST_TRIP     = 1'h0;
    localparam logic RST_PD       = 1'h0;
    localparam logic [2:0] RST_EVT = 3'h0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage : pmsc_pkg

// File: core/pmsc_core.sv
/*
 * Power monitor and stop-mode control: undervolt detect and supply
 * warning flags with acknowledges, interrupt and reset enables, trip
 * point selects and write-once power-down controls, behind an APB slave.
 * Assumes analog comparators drive the two detector inputs
 * asynchronously, stop_mode_in and partial_wake_in come from logic on
 * pclk, and por_n is the power-on reset only.
 */
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module pmsc_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        por_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        undervolt_detector_in,
    input  wire logic        supply_warning_detector_in,
    input  wire logic        stop_mode_in,
    input  wire logic        partial_wake_in,
    output logic             undervolt_detector_on,
    output logic             detect_trip_select,
    output logic             warning_trip_select,
    output logic             undervolt_reset_req,
    output logic             full_powerdown_mode,
    output logic             partial_powerdown_mode,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic       det_s1_r, det_s2_r, det_s3_r, det_f_r;
    logic       wrn_s1_r, wrn_s2_r, wrn_s3_r, wrn_f_r;
    logic       undervolt_detect_flag_r;
    logic       undervolt_irq_enable_r;
    logic       undervolt_reset_enable_r;
    logic       undervolt_stop_enable_r;
    logic       undervolt_logic_enable_r;
    logic       c1_once_r;
    logic       supply_warning_flag_r;
    logic       detect_trip_select_r;
    logic       warning_trip_select_r;
    logic       partial_powerdown_flag_r;
    logic       powerdown_allow_r;
    logic       powerdown_kind_select_r;
    logic       c2_once_r;
    logic [2:0] evt_sts_r;
    logic [2:0] evt_mask_r;
    logic [31:0] prdata_r;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire logic       apb_setup = psel & ~penable;
    wire logic       apb_acc   = psel & penable;
    wire logic       sel_c1    = (paddr == pmsc_pkg::PMSC_ADDR_CTRL1);
    wire logic       sel_c2    = (paddr == pmsc_pkg::PMSC_ADDR_CTRL2);
    wire logic       sel_sts   = (paddr == pmsc_pkg::PMSC_ADDR_EVT_STS);
    wire logic       sel_msk   = (paddr == pmsc_pkg::PMSC_ADDR_EVT_MASK);
    wire logic       addr_hit  = sel_c1 | sel_c2 | sel_sts | sel_msk;
    wire logic       apb_wr    = apb_acc & pwrite & addr_hit;
    wire logic       wr_c1     = apb_wr & sel_c1;
    wire logic       wr_c2     = apb_wr & sel_c2;
    wire logic       wr_sts    = apb_wr & sel_sts;
    wire logic       wr_msk    = apb_wr & sel_msk;
    wire logic [7:0] wd        = pwdata[7:0];

    // Zero wait states; unmapped addresses answer with an error
    // Writes land at the end of the access phase, one per transfer
    assign pready  = 1'h1;
    assign pslverr = apb_acc & ~addr_hit;
    assign prdata  = prdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Detector input synchronisers, three stages with agreement filter.
    // The comparators are asynchronous to pclk, so only the second
    // stage reads the first; a metastable first stage reaches no logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_s1_r <= 1'h0;
            det_s2_r <= 1'h0;
            det_s3_r <= 1'h0;
            wrn_s1_r <= 1'h0;
            wrn_s2_r <= 1'h0;
            wrn_s3_r <= 1'h0;
        end else begin
            det_s1_r <= undervolt_detector_in;
            det_s2_r <= det_s1_r;
            det_s3_r <= det_s2_r;
            wrn_s1_r <= supply_warning_detector_in;
            wrn_s2_r <= wrn_s1_r;
            wrn_s3_r <= wrn_s2_r;
        end
    end

    // Filtered levels change only when stages two and three agree
    // A one-cycle glitch on a comparator is dropped here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_f_r <= 1'h0;
            wrn_f_r <= 1'h0;
        end else begin
            if (det_s2_r == det_s3_r) det_f_r <= det_s3_r;
            if (wrn_s2_r == wrn_s3_r) wrn_f_r <= wrn_s3_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detection gating and events
    // With stop enable clear the detector is off in stop, so no
    // detect event can be raised there however low the supply falls
    wire logic det_alive = undervolt_logic_enable_r
                         & (~stop_mode_in | undervolt_stop_enable_r);
    wire logic det_evt   = det_alive & det_f_r;
    wire logic wrn_evt   = wrn_f_r;
    wire logic det_ack   = wr_c1 & wd[pmsc_pkg::C1_DETECT_ACK];
    wire logic wrn_ack   = wr_c2 & wd[pmsc_pkg::C2_WARN_ACK];
    wire logic ppd_ack   = wr_c2 & wd[pmsc_pkg::C2_PPD_ACK];

    // Next values of the sticky flags; a new event wins over the ack
    wire logic det_flag_nxt = det_evt
                            | (undervolt_detect_flag_r & ~det_ack);
    wire logic wrn_flag_nxt = wrn_evt
                            | (supply_warning_flag_r & ~wrn_ack);
    wire logic ppd_flag_nxt = partial_wake_in
                            | (partial_powerdown_flag_r & ~ppd_ack);

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags
    // Ack and event in one cycle leave the flag set, so a supply that
    // is still low can never be acknowledged away unseen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undervolt_detect_flag_r  <= 1'h0;
            supply_warning_flag_r    <= 1'h0;
            partial_powerdown_flag_r <= 1'h0;
        end else begin
            undervolt_detect_flag_r  <= det_flag_nxt;
            supply_warning_flag_r    <= wrn_flag_nxt;
            partial_powerdown_flag_r <= ppd_flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register 1 enables; logic enable is write-once
    // Any write arms the lock, so a write that only changes enables
    // still freezes the logic enable until the next reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undervolt_irq_enable_r   <= pmsc_pkg::RST_IRQ_EN;
            undervolt_reset_enable_r <= pmsc_pkg::RST_RST_EN;
            undervolt_stop_enable_r  <= pmsc_pkg::RST_STOP_EN;
            undervolt_logic_enable_r <= pmsc_pkg::RST_LOGIC_EN;
            c1_once_r                <= 1'h0;
        end else if (wr_c1) begin
            undervolt_irq_enable_r   <= wd[pmsc_pkg::C1_IRQ_EN];
            undervolt_reset_enable_r <= wd[pmsc_pkg::C1_RST_EN];
            undervolt_stop_enable_r  <= wd[pmsc_pkg::C1_STOP_EN];
            c1_once_r                <= 1'h1;
            if (!c1_once_r) begin
                undervolt_logic_enable_r <= wd[pmsc_pkg::C1_LOGIC_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-once power-down controls of register 2
    // Both bits lock together on the first write after reset, so the
    // stop logic may trust the chosen mode until the next reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powerdown_allow_r       <= pmsc_pkg::RST_PD;
            powerdown_kind_select_r <= pmsc_pkg::RST_PD;
            c2_once_r               <= 1'h0;
        end else if (wr_c2 && !c2_once_r) begin
            powerdown_allow_r       <= wd[pmsc_pkg::C2_PD_ALLOW];
            powerdown_kind_select_r <= wd[pmsc_pkg::C2_PD_KIND];
            c2_once_r               <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trip selects survive every reset but power-on
    // An undervolt reset thus keeps the thresholds software chose,
    // and the comparators do not jump while the supply recovers
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            detect_trip_select_r  <= pmsc_pkg::RST_TRIP;
            warning_trip_select_r <= pmsc_pkg::RST_TRIP;
        end else if (wr_c2) begin
            detect_trip_select_r  <= wd[pmsc_pkg::C2_DET_TRIP];
            warning_trip_select_r <= wd[pmsc_pkg::C2_WARN_TRIP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status (write one to clear, set wins) and mask
    // A source still active re-sets its bit in the cycle of the clear
    wire logic [2:0] evt_set = {partial_wake_in, wrn_evt, det_evt};
    wire logic [2:0] evt_clr = wr_sts ? wd[2:0] : 3'h0;
    wire logic [2:0] evt_sts_nxt = evt_set | (evt_sts_r & ~evt_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_sts_r  <= pmsc_pkg::RST_EVT;
            evt_mask_r <= pmsc_pkg::RST_EVT;
        end else begin
            evt_sts_r <= evt_sts_nxt;
            if (wr_msk) evt_mask_r <= wd[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data; acknowledge bits always read zero
    wire logic [7:0] rd_c1 = {undervolt_detect_flag_r, 1'h0,
                              undervolt_irq_enable_r,
                              undervolt_reset_enable_r,
                              undervolt_stop_enable_r,
                              undervolt_logic_enable_r, 2'h0};
    wire logic [7:0] rd_c2 = {supply_warning_flag_r, 1'h0,
                              detect_trip_select_r,
                              warning_trip_select_r,
                              partial_powerdown_flag_r, 1'h0,
                              powerdown_allow_r,
                              powerdown_kind_select_r};
    logic [31:0] rdata_nxt;

    // Address mux for reads
    always_comb begin
        rdata_nxt = pmsc_pkg::RST_RDATA;
        if (sel_c1) begin
            rdata_nxt = {24'h00_0000, rd_c1};
        end else if (sel_c2) begin
            rdata_nxt = {24'h00_0000, rd_c2};
        end else if (sel_sts) begin
            rdata_nxt = {29'h0000_0000, evt_sts_r};
        end else if (sel_msk) begin
            rdata_nxt = {29'h0000_0000, evt_mask_r};
        end
    end

    // Read data captured at the end of the setup cycle, so prdata comes
    // from a flip-flop and stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= pmsc_pkg::RST_RDATA;
        end else if (apb_setup && !pwrite) begin
            prdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to the analog side, reset controller and stop logic
    // The reset request is gated by the logic enable but not by stop, so
    // a detector with its logic enable or its reset enable clear can never reset the system from a stale flag
    assign undervolt_detector_on  = det_alive;
    assign detect_trip_select     = detect_trip_select_r;
    assign warning_trip_select    = warning_trip_select_r;
    assign undervolt_reset_req    = undervolt_detect_flag_r
                                  & undervolt_reset_enable_r
                                  & undervolt_logic_enable_r;
    assign full_powerdown_mode    = powerdown_allow_r
                                  & ~powerdown_kind_select_r;
    assign partial_powerdown_mode = powerdown_allow_r
                                  & powerdown_kind_select_r;
    assign irq = (undervolt_detect_flag_r & undervolt_irq_enable_r)
               | (|(evt_sts_r & evt_mask_r));

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_DETECT_SET: assert property (@(posedge pclk) disable iff (!presetn)
        det_evt |=> undervolt_detect_flag_r)
        else $error("detect event did not set the flag");

    AST_DETECT_ACK: assert property (@(posedge pclk) disable iff (!presetn)
        det_ack && !det_evt |=> !undervolt_detect_flag_r)
        else $error("detect ack did not clear the flag");

    AST_ACK_READS_ZERO: assert property (@(posedge pclk)
        disable iff (!presetn)
        apb_setup && !pwrite && (sel_c1 || sel_c2)
        |=> !prdata[pmsc_pkg::C1_DETECT_ACK]
        && !(prdata[pmsc_pkg::C2_PPD_ACK] && $past(sel_c2)))
        else $error("acknowledge bit read back as one");

    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        undervolt_detect_flag_r && undervolt_irq_enable_r
        |-> irq)
        else $error("interrupt low while detect flag enabled");

    AST_RESET_REQ: assert property (@(posedge pclk) disable iff (!presetn)
        det_evt && undervolt_reset_enable_r && !wr_c1
        |=> undervolt_reset_req)
        else $error("reset request missing after detect");

    AST_STOP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode_in && !undervolt_stop_enable_r
        |-> !undervolt_detector_on)
        else $error("detector active in stop without enable");

    AST_LOGIC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !undervolt_logic_enable_r
        |=> !$rose(undervolt_detect_flag_r))
        else $error("detect flag rose with logic disabled");

    AST_ONCE_C1: assert property (@(posedge pclk) disable iff (!presetn)
        c1_once_r && wr_c1
        |=> $stable(undervolt_logic_enable_r))
        else $error("once-only enable changed on a second write");

    AST_WARN_PRESENT: assert property (@(posedge pclk)
        disable iff (!presetn)
        wrn_f_r ##1 wrn_f_r |-> supply_warning_flag_r)
        else $error("warning flag clear while warning present");

    AST_WARN_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        supply_warning_flag_r && !wrn_ack
        |=> supply_warning_flag_r)
        else $error("warning flag dropped without ack");

    AST_PPD_SET: assert property (@(posedge pclk) disable iff (!presetn)
        partial_wake_in |=> partial_powerdown_flag_r
        ##1 (partial_powerdown_flag_r || $past(ppd_ack)))
        else $error("partial power-down flag not set on wake");

    AST_PD_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        c2_once_r && wr_c2 |=> $stable(powerdown_allow_r)
        && $stable(powerdown_kind_select_r))
        else $error("write-once power-down control changed");

    AST_WARN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        wrn_ack && !wrn_evt |=> !supply_warning_flag_r)
        else $error("warning ack without warning did not clear");

    AST_PPD_ACK: assert property (@(posedge pclk) disable iff (!presetn)
        ppd_ack && !partial_wake_in
        |=> !partial_powerdown_flag_r)
        else $error("partial power-down ack did not clear the flag");

    AST_TRIP_WRITE: assert property (@(posedge pclk)
        disable iff (!presetn || !por_n)
        wr_c2 |=> detect_trip_select_r
        == $past(wd[pmsc_pkg::C2_DET_TRIP]))
        else $error("detect trip select did not take the write");

endmodule : pmsc_core

`default_nettype wire

// File: verif/pmsc_bench.sv
/*
 * Self-checking bench for the power monitor and stop-mode control block.
 * Assumes the core carries its own assertions; the bench is the APB master
 * and drives the comparator, stop and wake inputs itself.
 */
`timescale 1ns/1ns
`default_nettype none

module pmsc_bench;

    logic        pclk;
    logic        presetn;
    logic        por_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic        pready;
    logic        pslverr;
    logic        rerr;
    logic        uv_in;
    logic        warn_in;
    logic        stop_in;
    logic        wake_in;
    logic        det_on;
    logic        det_trip;
    logic        warn_trip;
    logic        rst_req;
    logic        full_pd;
    logic        part_pd;
    logic        irq;
    int          fail_count;
    int          tests_run;

    ////////////////////////////////////////////////////////////////////////
    // Device under test
    pmsc_core dut_u (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .por_n                     (por_n),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .prdata                    (prdata),
        .pready                    (pready),
        .pslverr                   (pslverr),
        .undervolt_detector_in     (uv_in),
        .supply_warning_detector_in(warn_in),
        .stop_mode_in              (stop_in),
        .partial_wake_in           (wake_in),
        .undervolt_detector_on     (det_on),
        .detect_trip_select        (det_trip),
        .warning_trip_select       (warn_trip),
        .undervolt_reset_req       (rst_req),
        .full_powerdown_mode       (full_pd),
        .partial_powerdown_mode    (part_pd),
        .irq                       (irq)
    );

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparisons
    task finish_test;
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t read %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task cmp_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s is %b expected %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    ////////////////////////////////////////////////////////////////////////
    // APB master: setup, access held until pready, then release
    task apb(input logic wr, input logic [11:0] addr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                fail_count++;
                $display("ERROR %0t no pready", $time);
                finish_test();
            end
            @(posedge pclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] addr, input logic [31:0] d);
        apb(1'b1, addr, d);
    endtask : wr

    task rd(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        cmp_reg(rdat, exp);
    endtask : rd

    // Let the edge's updates land before looking at outputs
    task settle;
        @(negedge pclk);
    endtask : settle

    // Short low pulse on the system reset or the power-on reset
    task pulse_rst(input logic power_on);
        @(posedge pclk);
        if (power_on) por_n <= 1'b0; else presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        por_n   <= 1'b1;
        presetn <= 1'b1;
    endtask : pulse_rst

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fail_count = 0;
        tests_run = 0;
        {presetn, por_n, psel, penable, pwrite} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        {uv_in, warn_in, stop_in, wake_in} = 4'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        por_n   <= 1'b1;
        // Reset values and an unmapped access
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0014);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        cmp_reg(rdat, 32'h0000_0000);
        cmp_bit(rerr, 1'b1, "unmapped error");
        // Detect flag, interrupt and reset request, then acknowledge
        wr(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0034);
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0034);
        uv_in <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_00B4);
        settle();
        cmp_bit(irq, 1'b1, "irq");
        cmp_bit(rst_req, 1'b1, "reset req");
        uv_in <= 1'b0;
        repeat (6) @(posedge pclk);
        settle();
        cmp_bit(irq, 1'b1, "irq held");
        wr(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0070);
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0034);
        settle();
        cmp_bit(irq, 1'b0, "irq after ack");
        cmp_bit(rst_req, 1'b0, "reset req off");
        // Event status, mask and clear by writing one
        rd(pmsc_pkg::PMSC_ADDR_EVT_STS, 32'h0000_0001);
        wr(pmsc_pkg::PMSC_ADDR_EVT_MASK, 32'h0000_0001);
        settle();
        cmp_bit(irq, 1'b1, "irq unmasked");
        wr(pmsc_pkg::PMSC_ADDR_EVT_STS, 32'h0000_0001);
        rd(pmsc_pkg::PMSC_ADDR_EVT_STS, 32'h0000_0000);
        settle();
        cmp_bit(irq, 1'b0, "irq cleared");
        wr(pmsc_pkg::PMSC_ADDR_EVT_MASK, 32'h0000_0000);
        // Third write cannot clear the logic enable; stop behaviour
        wr(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0000);
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0004);
        @(posedge pclk);
        stop_in <= 1'b1;
        uv_in   <= 1'b1;
        settle();
        cmp_bit(det_on, 1'b0, "detector in stop");
        repeat (8) @(posedge pclk);
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0004);
        wr(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0008);
        settle();
        cmp_bit(det_on, 1'b1, "detector stop on");
        repeat (6) @(posedge pclk);
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_008C);
        uv_in   <= 1'b0;
        stop_in <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0040);
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0004);
        // Trip selects and write-once power-down controls
        wr(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0033);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0033);
        settle();
        cmp_bit(det_trip, 1'b1, "detect trip");
        cmp_bit(warn_trip, 1'b1, "warn trip");
        cmp_bit(part_pd, 1'b1, "partial mode");
        cmp_bit(full_pd, 1'b0, "full mode");
        wr(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0000);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0003);
        wr(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0030);
        // Partial power-down wake flag and its acknowledge
        @(posedge pclk);
        wake_in <= 1'b1;
        @(posedge pclk);
        wake_in <= 1'b0;
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_003B);
        wr(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0034);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0033);
        // Warning flag: set, refused ack while present, sticky, cleared
        warn_in <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_00B3);
        wr(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0070);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_00B3);
        warn_in <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_00B3);
        wr(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0070);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0033);
        // Warning and wake events reach the status register and irq
        rd(pmsc_pkg::PMSC_ADDR_EVT_STS, 32'h0000_0007);
        wr(pmsc_pkg::PMSC_ADDR_EVT_MASK, 32'h0000_0006);
        settle();
        cmp_bit(irq, 1'b1, "irq warn and wake");
        wr(pmsc_pkg::PMSC_ADDR_EVT_STS, 32'h0000_0007);
        rd(pmsc_pkg::PMSC_ADDR_EVT_STS, 32'h0000_0000);
        settle();
        cmp_bit(irq, 1'b0, "irq events cleared");
        // System reset keeps trip selects and re-arms write-once bits
        pulse_rst(1'b0);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0030);
        rd(pmsc_pkg::PMSC_ADDR_CTRL1, 32'h0000_0014);
        wr(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0032);
        settle();
        cmp_bit(full_pd, 1'b1, "full mode");
        cmp_bit(part_pd, 1'b0, "partial mode");
        // Power-on reset clears the trip selects
        pulse_rst(1'b1);
        rd(pmsc_pkg::PMSC_ADDR_CTRL2, 32'h0000_0002);
        settle();
        cmp_bit(det_trip, 1'b0, "detect trip");
        cmp_bit(warn_trip, 1'b0, "warn trip");
        finish_test();
    end

endmodule : pmsc_bench

`default_nettype wire
